/* core/thermal_warning_monitor.sv */
// The address-and-strobe port was left to the implementer.
module thermal_warning_monitor #(
   parameter int TEMP_W = thermal_pkg::TEMP_W
) (
   input  wire logic                           clk,
   input  wire logic                           rst_b,
   input  wire logic [1:0]                     power_state,
   input  wire logic [TEMP_W-1:0]              temp_code,
   input  wire logic                           shutdown_level,
   input  wire thermal_pkg::reg_req_t          req,
   output logic [thermal_pkg::DATA_W-1:0]      rdata,
   output logic                                temp_int,
   output logic                                sys_reset_req
);
   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   logic              sd_s1_r;
   logic              sd_s2_r;
   logic [TEMP_W-1:0] tmp_s1_r;
   logic [TEMP_W-1:0] tmp_s2_r;
   logic [TEMP_W-1:0] tmp_s3_r;
   logic [TEMP_W-1:0] tmp_stable_r;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sd_s1_r  <= 1'b0;
         sd_s2_r  <= 1'b0;
         tmp_s1_r <= '0;
         tmp_s2_r <= '0;
      end else begin
         sd_s1_r  <= shutdown_level;
         sd_s2_r  <= sd_s1_r;
         tmp_s1_r <= temp_code;
         tmp_s2_r <= tmp_s1_r;
      end
   end

   // Multi-bit code is taken only once two synced samples agree, so a skewed word is never compared
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tmp_s3_r     <= '0;
         tmp_stable_r <= '0;
      end else begin
         tmp_s3_r <= tmp_s2_r;
         if (tmp_s2_r == tmp_s3_r) begin
            tmp_stable_r <= tmp_s2_r;
         end
      end
   end

   logic active;
   assign active = (power_state == 2'(thermal_pkg::PWR_ON)) ||
                   (power_state == 2'(thermal_pkg::PWR_SLEEP));

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   logic [1:0] thr_sel_r;
   logic       hyst_sel_r;
   logic       mask_r;
   logic       wr_ctrl;
   logic       wr_int;
   logic       wr_mask;

   assign wr_ctrl = req.wr && (req.addr == thermal_pkg::ADDR_THERM_CTRL);
   assign wr_int  = req.wr && (req.addr == thermal_pkg::ADDR_INT_STATUS_ONE);
   assign wr_mask = req.wr && (req.addr == thermal_pkg::ADDR_INT_MASK_ONE);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         thr_sel_r  <= thermal_pkg::THR_SEL_RST;
         hyst_sel_r <= thermal_pkg::HYST_SEL_RST;
      end else if (wr_ctrl) begin
         thr_sel_r  <= req.wdata[thermal_pkg::BIT_THR_HI:thermal_pkg::BIT_THR_LO];
         hyst_sel_r <= req.wdata[thermal_pkg::BIT_HYST_SEL];
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mask_r <= thermal_pkg::MASK_RST;
      end else if (wr_mask) begin
         mask_r <= req.wdata[thermal_pkg::BIT_EVENT];
      end
   end

   // ----------------------------------------------------------------
   // Warning detection
   // ----------------------------------------------------------------
   logic warn_r;

   warn_comparator #(
      .TEMP_W   (TEMP_W)
   ) u_cmp (
      .clk      (clk),
      .rst_b    (rst_b),
      .active   (active),
      .temp     (tmp_stable_r),
      .thr_sel  (thr_sel_r),
      .hyst_sel (hyst_sel_r),
      .warn_r   (warn_r)
   );

   logic warn_d_r;
   logic event_r;
   logic change;

   assign change = warn_r ^ warn_d_r;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         warn_d_r <= 1'b0;
      end else begin
         warn_d_r <= warn_r;
      end
   end

   // Set wins over a coincident write-one clear
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         event_r <= 1'b0;
      end else if (change) begin
         event_r <= 1'b1;
      end else if (wr_int && req.wdata[thermal_pkg::BIT_EVENT]) begin
         event_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         temp_int <= 1'b0;
      end else begin
         temp_int <= (event_r || change) && !mask_r;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sys_reset_req <= 1'b0;
      end else begin
         sys_reset_req <= sd_s2_r && active;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata <= '0;
      end else begin
         rdata <= '0;
         if (req.rd) begin
            unique case (req.addr)
               thermal_pkg::ADDR_THERM_CTRL: begin
                  rdata[thermal_pkg::BIT_THR_HI:thermal_pkg::BIT_THR_LO] <= thr_sel_r;
                  rdata[thermal_pkg::BIT_HYST_SEL] <= hyst_sel_r;
               end
               thermal_pkg::ADDR_SYS_STATUS: begin
                  rdata[thermal_pkg::BIT_WARN_STS] <= warn_r;
               end
               thermal_pkg::ADDR_INT_STATUS_ONE: begin
                  rdata[thermal_pkg::BIT_EVENT] <= event_r;
               end
               thermal_pkg::ADDR_INT_MASK_ONE: begin
                  rdata[thermal_pkg::BIT_EVENT] <= mask_r;
               end
               default: begin
                  rdata <= '0;
               end
            endcase
         end
      end
   end
endmodule // thermal_warning_monitor

/* core/thermal_pkg.sv */
package thermal_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam int          ADDR_W              = 16;
   localparam int          DATA_W              = 16;
   localparam int          TEMP_W              = 8;
   localparam logic [15:0] ADDR_THERM_CTRL     = 16'h4002;
   localparam logic [15:0] ADDR_SYS_STATUS     = 16'h400d;
   localparam logic [15:0] ADDR_INT_STATUS_ONE = 16'h4011;
   localparam logic [15:0] ADDR_INT_MASK_ONE   = 16'h4019;

   localparam int BIT_HYST_SEL   = 3;
   localparam int BIT_THR_LO     = 0;
   localparam int BIT_THR_HI     = 1;
   localparam int BIT_WARN_STS   = 15;
   localparam int BIT_EVENT      = 1;

   localparam logic [1:0] THR_SEL_RST  = 2'h2;
   localparam logic       HYST_SEL_RST = 1'b1;
   localparam logic       MASK_RST     = 1'b1;

   // ----------------------------------------------------------------
   // Temperatures in degrees C
   // ----------------------------------------------------------------
   localparam logic [7:0] THR_90   = 8'h5a;
   localparam logic [7:0] THR_100  = 8'h64;
   localparam logic [7:0] THR_110  = 8'h6e;
   localparam logic [7:0] THR_120  = 8'h78;
   localparam logic [7:0] HYST_8   = 8'h08;
   localparam logic [7:0] HYST_16  = 8'h10;

   typedef enum logic [1:0] {
      PWR_OFF,
      PWR_ON,
      PWR_SLEEP,
      PWR_OTHER
   } power_state_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } reg_req_t;

   function automatic logic [7:0] thr_degrees(input logic [1:0] sel);
      logic [7:0] t;
      t = THR_90;
      unique case (sel)
         2'h0: t = THR_90;
         2'h1: t = THR_100;
         2'h2: t = THR_110;
         2'h3: t = THR_120;
      endcase
      return t;
   endfunction
endpackage

/* core/warn_comparator.sv */
module warn_comparator #(
   parameter int TEMP_W = thermal_pkg::TEMP_W
) (
   input  wire logic              clk,
   input  wire logic              rst_b,
   input  wire logic              active,
   input  wire logic [TEMP_W-1:0] temp,
   input  wire logic [1:0]        thr_sel,
   input  wire logic              hyst_sel,
   output logic                   warn_r
);
   logic [TEMP_W-1:0] thr;
   logic [TEMP_W-1:0] hyst;
   logic [TEMP_W-1:0] release_lvl;
   logic              warn_nxt;

   always_comb begin
      thr         = TEMP_W'(thermal_pkg::thr_degrees(thr_sel));
      hyst        = hyst_sel ? TEMP_W'(thermal_pkg::HYST_16) : TEMP_W'(thermal_pkg::HYST_8);
      release_lvl = thr - hyst;
      warn_nxt    = warn_r;
      if (!active) begin
         warn_nxt = 1'b0;
      end else if (!warn_r && temp >= thr) begin
         warn_nxt = 1'b1;
      end else if (warn_r && temp < release_lvl) begin
         warn_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         warn_r <= 1'b0;
      end else begin
         warn_r <= warn_nxt;
      end
   end
endmodule // warn_comparator

/* test/thermal_warning_monitor_assertions.sv */
module twm_checker #(
   parameter int TEMP_W = 8
) (
   input wire logic                  clk,
   input wire logic                  rst_b,
   input wire logic [1:0]            power_state,
   input wire logic [TEMP_W-1:0]     temp_code,
   input wire logic                  shutdown_level,
   input wire thermal_pkg::reg_req_t req,
   input wire logic [15:0]           rdata,
   input wire logic                  temp_int,
   input wire logic                  sys_reset_req
);
   // ----------
   // Properties
   // ----------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_off_rd;
      (power_state == 2'h0) [*3] ##0 (req.rd && req.addr == 16'h400d);
   endsequence
   property p_idle; !req.rd |=> rdata == 16'h0000; endproperty
   a_idle: assert property (p_idle) else $error("rdata not zero");
   property p_unmap; req.rd && !(req.addr inside {16'h4002, 16'h400d, 16'h4011, 16'h4019}) |=> rdata == 0; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read");
   property p_ctrl; req.rd && req.addr == 16'h4002 |=> rdata[15:4] == 12'h000 && !rdata[2]; endproperty
   a_ctrl: assert property (p_ctrl) else $error("control fields");
   property p_sts; req.rd && req.addr == 16'h400d |=> rdata[14:0] == 15'h0000; endproperty
   a_sts: assert property (p_sts) else $error("status fields");
   property p_flag; req.rd && req.addr == 16'h4011 |=> rdata[15:2] == 14'h0000 && !rdata[0]; endproperty
   a_flag: assert property (p_flag) else $error("flag fields");
   property p_off; s_off_rd |=> !rdata[15]; endproperty
   a_off: assert property (p_off) else $error("warning while off");
   property p_hold; temp_int && !req.wr && !$past(req.wr) |=> temp_int; endproperty
   a_hold: assert property (p_hold) else $error("interrupt dropped");
   property p_drop; $fell(temp_int) |-> $past(req.wr) || $past(req.wr, 2); endproperty
   a_drop: assert property (p_drop) else $error("interrupt fell");
   property p_shut; (shutdown_level && power_state inside {2'h1, 2'h2}) [*4] |=> sys_reset_req; endproperty
   a_shut: assert property (p_shut) else $error("no system reset");
   property p_noshut; power_state == 2'h0 |=> !sys_reset_req; endproperty
   a_noshut: assert property (p_noshut) else $error("reset while off");
endmodule // twm_checker

bind thermal_warning_monitor twm_checker #(.TEMP_W(TEMP_W)) i_chk (.clk(clk), .rst_b(rst_b),
   .power_state(power_state), .temp_code(temp_code), .shutdown_level(shutdown_level), .req(req),
   .rdata(rdata), .temp_int(temp_int), .sys_reset_req(sys_reset_req));

/* test/test_thermal_warning_monitor.sv */
module test_thermal_warning_monitor;
   timeunit 1ns;
   timeprecision 100ps;
   logic                  clk = 1'b0;
   logic                  rst_b = 1'b0;
   logic [1:0]            power_state = 2'h1;
   logic [7:0]            temp_code = 8'h19;
   logic                  shutdown_level = 1'b0;
   thermal_pkg::reg_req_t req = '0;
   logic [15:0]           rdata;
   logic                  temp_int;
   logic                  sys_reset_req;
   int                    fail_count = 0;
   int                    compares = 0;
   int                    cyc = 0;

   thermal_warning_monitor #(.TEMP_W(8)) i_dut (.clk(clk), .rst_b(rst_b), .power_state(power_state),
      .temp_code(temp_code), .shutdown_level(shutdown_level), .req(req), .rdata(rdata),
      .temp_int(temp_int), .sys_reset_req(sys_reset_req));

   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fail_count++;
         results();
      end
   end
   // -------------
   // Bus and checks
   // -------------
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic st(input logic [7:0] t);
      @(posedge clk) temp_code <= t;
      wt(6);
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk) req.wr <= 1'b0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [15:0] e);
      @(posedge clk) req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk) req.rd <= 1'b0;
      #1 chk("rdata", e, rdata);
   endtask
   // ---------
   // Scenarios
   // ---------
   task automatic t_reset();
      rd(16'h4002, 16'h000a);
      rd(16'h400d, 16'h0000);
      rd(16'h4011, 16'h0000);
      rd(16'h4019, 16'h0002);
      rd(16'h4003, 16'h0000);
   endtask
   task automatic t_levels();
      logic [7:0] thr;
      logic [7:0] hy;
      wr(16'h4019, 16'h0000);
      for (int s = 0; s < 4; s++) begin
         thr = 8'h5a + 8'(10 * s);
         hy = (s % 2 == 1) ? 8'h10 : 8'h08;
         wr(16'h4002, 16'((s % 2) * 8 + s));
         st(thr - 8'h01);
         rd(16'h400d, 16'h0000);
         st(thr);
         rd(16'h400d, 16'h8000);
         chk("temp_int", 16'h0001, {15'h0, temp_int});
         wr(16'h4011, 16'h0002);
         rd(16'h4011, 16'h0000);
         chk("temp_int", 16'h0000, {15'h0, temp_int});
         st(thr - hy);
         rd(16'h400d, 16'h8000);
         st(thr - hy - 8'h01);
         rd(16'h400d, 16'h0000);
         rd(16'h4011, 16'h0002);
         wr(16'h4011, 16'h0002);
      end
   endtask
   task automatic t_mask();
      wr(16'h4019, 16'h0002);
      st(8'h78);
      rd(16'h4011, 16'h0002);
      chk("temp_int", 16'h0000, {15'h0, temp_int});
      wr(16'h4019, 16'h0000);
      rd(16'h4019, 16'h0000);
      chk("temp_int", 16'h0001, {15'h0, temp_int});
      wr(16'h4011, 16'h0002);
      wr(16'h400d, 16'h0000);
      rd(16'h400d, 16'h8000);
   endtask
   task automatic t_power();
      @(posedge clk) power_state <= 2'h2;
      st(8'h78);
      rd(16'h400d, 16'h8000);
      @(posedge clk) shutdown_level <= 1'b1;
      wt(6);
      chk("sys_reset_req", 16'h0001, {15'h0, sys_reset_req});
      @(posedge clk) power_state <= 2'h0;
      wt(4);
      rd(16'h400d, 16'h0000);
      chk("sys_reset_req", 16'h0000, {15'h0, sys_reset_req});
   endtask
   task automatic results();
      if (fail_count == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      wt(2);
      rst_b <= 1'b1;
      t_reset();
      t_levels();
      t_mask();
      t_power();
      results();
   end
endmodule // test_thermal_warning_monitor
